/* src/flash_setup_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_setup_cfg.svh"
// Brings up the flash controller: map, address, strobe, timing, delay chain, then command
module flash_setup_host #(
  parameter int unsigned POLL_LIMIT = `POLL_LIMIT_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic        ddr_mode,
  input  wire logic        dll_auto,
  input  wire logic        has_address,
  input  wire logic        word_addressable,
  input  wire logic [3:0]  column_width,
  input  wire logic [5:0]  page_width,
  input  wire logic [8:0]  flash_mhz,
  input  wire logic [8:0]  bus_mhz,
  input  wire logic [31:0] top_addr,
  input  wire logic [31:0] flash_addr,
  input  wire logic [4:0]  sequence_index,
  input  wire logic [3:0]  coarse_delay,
  input  wire logic [2:0]  fine_delay,
  input  wire logic [3:0]  delay_offset,
  input  wire logic        freq_range_sel,
  input  wire logic [3:0]  ref_count,
  input  wire logic [3:0]  delay_resolution,
  output logic             busy,
  output logic             done,
  output logic             error,
  output logic [2:0]       error_code,
  output logic [15:0]      dev_addr,
  output logic [31:0]      dev_wdata,
  output logic             dev_wr_en,
  output logic             dev_rd_en,
  input  wire logic [31:0] dev_rdata,
  input  wire logic        dev_ack
);
  flash_setup_pkg::host_state_e state_q, state_d;
  logic [3:0]  step_q, step_d;
  logic [31:0] tries_q, tries_d;
  logic        done_q, done_d, err_q, err_d;
  logic [2:0]  code_q, code_d, check_code;
  logic        op_valid, op_done, poll_step, lock_seen;
  logic [15:0] step_addr;
  logic [31:0] step_data, dll_mode, dll_fields, op_rdata;

  function automatic logic [15:0] times(input logic [8:0] mhz, input logic [15:0] k);
    times = 16'({7'h00, mhz} * k);
  endfunction

  // Rejects settings the device cannot take before any register is touched
  always_comb begin
    check_code = flash_setup_pkg::ERR_NONE;
    // RQ1 address inside window
    if (has_address && flash_addr > `WINDOW_TOP)
      check_code = flash_setup_pkg::ERR_WINDOW;
    // RQ5 width limit
    else if (7'({1'b0, page_width} + {3'h0, column_width}) > `MAX_ADDR_BITS)
      check_code = flash_setup_pkg::ERR_WIDTH;
    // RQ18 index in table
    else if (sequence_index >= `SEQ_COUNT)
      check_code = flash_setup_pkg::ERR_INDEX;
    // RQ20 clock ratio floor
    else if (times(flash_mhz, `RATIO_MIN) <= times(bus_mhz, 16'h0001))
      check_code = flash_setup_pkg::ERR_CLOCK;
    // RQ21 DDR write ceiling
    else if (ddr_mode && times(flash_mhz, `WR_BUS_PERIODS) >=
             times(bus_mhz, `WR_LIMIT_PERIODS - `WR_FLASH_PERIODS))
      check_code = flash_setup_pkg::ERR_CLOCK;
  end

  // RQ12 bypass mode bits
  // RQ15 auto mode bits
  always_comb begin
    dll_mode = 32'h0000_0000;
    dll_mode[`DL_CHAIN_EN_BIT] = 1'b1;
    dll_mode[`DL_BYPASS_BIT]   = !dll_auto;
    dll_mode[`DL_AUTO_BIT]     = dll_auto;
    dll_fields = dll_mode;
    dll_fields[`DL_FREQ_BIT] = freq_range_sel;
    dll_fields[`DL_FINE_LSB +: 3] = fine_delay;
    if (dll_auto) begin
      dll_fields[`DL_OFFSET_LSB +: 4] = delay_offset;
      dll_fields[`DL_REF_LSB +: 4]    = ref_count;
      dll_fields[`DL_RES_LSB +: 4]    = delay_resolution;
    end else begin
      dll_fields[`DL_COARSE_LSB +: 4] = coarse_delay;
    end
  end

  assign poll_step = dll_auto ? (step_q == 4'hb) : (step_q == 4'ha);

  always_comb begin
    step_addr = `OFS_MODULE_CTRL;
    step_data = 32'h0000_0000;
    case (step_q)
      // RQ7 four top addresses
      4'h0, 4'h1, 4'h2, 4'h3: begin
        step_addr = `OFS_TOP_A1 + {12'h000, step_q[1:0], 2'h0};
        step_data = top_addr;
      end
      4'h4: begin
        step_addr = `OFS_ADDR_CFG;
        // RQ3 column width field
        step_data[`AC_COL_LSB +: 4] = column_width;
        step_data[`AC_WORD_BIT]     = word_addressable;
      end
      4'h5: begin
        step_addr = `OFS_MODULE_CTRL;
        step_data[`MC_DDR_EN_BIT] = ddr_mode;
        // RQ10 strobe source choice
        // RQ11 set picks external strobe
        step_data[`MC_STROBE_A_BIT] = ddr_mode ? (flash_mhz > `DDR_LOOP_MHZ)
                                               : (flash_mhz > `SDR_LOOP_MHZ);
      end
      4'h6: begin
        step_addr = `OFS_TIMING;
        // RQ16 SDR timing values
        // RQ17 DDR timing values
        step_data[`TM_SETUP_LSB +: 4] = `TM_CS_CYCLES;
        step_data[`TM_HOLD_LSB +: 4]  = `TM_CS_CYCLES;
        step_data[`TM_DHOLD_LSB +: 2] = ddr_mode ? `TM_DHOLD_DDR : `TM_DHOLD_SDR;
      end
      4'h7: begin
        step_addr = `OFS_DLL_CTRL_A;
        step_data = dll_mode;
      end
      4'h8: begin
        step_addr = `OFS_DLL_CTRL_A;
        step_data = dll_fields;
      end
      4'h9: begin
        step_addr = `OFS_DLL_CTRL_A;
        step_data = dll_fields;
        step_data[`DL_LOAD_BIT] = 1'b1;
      end
      // RQ12 poll then clear load
      // RQ15 loop on, clear load, poll
      4'ha: begin
        step_addr = dll_auto ? `OFS_DLL_CTRL_A : `OFS_LOCK_STATUS;
        step_data = dll_auto ? dll_fields : 32'h0000_0000;
        step_data[`DL_LOOP_ON_BIT] = dll_auto;
      end
      4'hb: begin
        step_addr = dll_auto ? `OFS_LOCK_STATUS : `OFS_DLL_CTRL_A;
        step_data = dll_auto ? 32'h0000_0000 : dll_fields;
      end
      4'hc: begin
        step_addr = `OFS_FLASH_ADDR;
        // RQ2 base for addressless commands
        step_data = has_address ? flash_addr : `WINDOW_BASE;
      end
      4'hd: begin
        step_addr = `OFS_IP_COMMAND;
        // RQ19 index write starts sequence
        step_data[`IPC_SEQ_LSB +: 4] = sequence_index[3:0];
      end
      default: step_addr = `OFS_MODULE_CTRL;
    endcase
  end

  assign lock_seen = op_rdata[`LS_LOCK_BIT];
  assign op_valid  = (state_q == flash_setup_pkg::ST_ISSUE);

  always_comb begin
    state_d = state_q;
    step_d  = step_q;
    tries_d = tries_q;
    done_d  = 1'b0;
    err_d   = 1'b0;
    code_d  = code_q;
    case (state_q)
      flash_setup_pkg::ST_IDLE: begin
        if (start)
          state_d = flash_setup_pkg::ST_CHECK;
      end
      flash_setup_pkg::ST_CHECK: begin
        code_d  = check_code;
        step_d  = 4'h0;
        tries_d = 32'h0;
        if (check_code != flash_setup_pkg::ERR_NONE) begin
          err_d   = 1'b1;
          state_d = flash_setup_pkg::ST_IDLE;
        end else begin
          state_d = flash_setup_pkg::ST_ISSUE;
        end
      end
      flash_setup_pkg::ST_ISSUE: begin
        state_d = flash_setup_pkg::ST_WAIT;
      end
      flash_setup_pkg::ST_WAIT: begin
        if (op_done) begin
          state_d = flash_setup_pkg::ST_ISSUE;
          if (poll_step && !lock_seen) begin
            tries_d = tries_q + 32'h1;
            if (tries_q >= POLL_LIMIT - 1) begin
              code_d  = flash_setup_pkg::ERR_LOCK;
              err_d   = 1'b1;
              state_d = flash_setup_pkg::ST_IDLE;
            end
          end else if (step_q == `LAST_STEP) begin
            done_d  = 1'b1;
            state_d = flash_setup_pkg::ST_IDLE;
          end else begin
            step_d = step_q + 4'h1;
          end
        end
      end
      default: state_d = flash_setup_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= flash_setup_pkg::ST_IDLE;
      step_q  <= 4'h0;
      tries_q <= 32'h0;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
      code_q  <= flash_setup_pkg::ERR_NONE;
    end else if (clk_en) begin
      state_q <= state_d;
      step_q  <= step_d;
      tries_q <= tries_d;
      done_q  <= done_d;
      err_q   <= err_d;
      code_q  <= code_d;
    end
  end

  reg_port_engine u_port (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .op_valid  (op_valid),
    .op_write  (!poll_step),
    .op_addr   (step_addr),
    .op_wdata  (step_data),
    .op_done   (op_done),
    .op_rdata  (op_rdata),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_wr_en (dev_wr_en),
    .dev_rd_en (dev_rd_en),
    .dev_rdata (dev_rdata),
    .dev_ack   (dev_ack)
  );

  assign busy       = (state_q != flash_setup_pkg::ST_IDLE);
  assign done       = done_q;
  assign error      = err_q;
  assign error_code = code_q;

  logic wr_addr_reg, wr_cfg, wr_mod, wr_tim, wr_dll;
  assign wr_addr_reg = dev_wr_en && dev_addr == `OFS_FLASH_ADDR;
  assign wr_cfg      = dev_wr_en && dev_addr == `OFS_ADDR_CFG;
  assign wr_mod      = dev_wr_en && dev_addr == `OFS_MODULE_CTRL;
  assign wr_tim      = dev_wr_en && dev_addr == `OFS_TIMING;
  assign wr_dll      = dev_wr_en && dev_addr == `OFS_DLL_CTRL_A;

  addr_window_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ1
    wr_addr_reg |-> dev_wdata <= `WINDOW_TOP) else $error("flash address outside window");
  addr_base_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ2
    (wr_addr_reg && !has_address) |-> dev_wdata == `WINDOW_BASE)
    else $error("addressless command without base");
  column_width_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ3
    wr_cfg |-> dev_wdata[`AC_COL_LSB +: 4] == column_width
    && page_width + column_width <= 7'h20) else $error("address config wrong");
  strobe_pick_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ10
    wr_mod |-> dev_wdata[`MC_STROBE_A_BIT] ==
    (ddr_mode ? flash_mhz > 9'h042 : flash_mhz > 9'h085))
    else $error("strobe source mispicked");
  bypass_bits_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ12
    (wr_dll && !dll_auto) |-> dev_wdata[`DL_BYPASS_BIT] && !dev_wdata[`DL_AUTO_BIT]
    && dev_wdata[`DL_CHAIN_EN_BIT] && !dev_wdata[`DL_LOOP_ON_BIT])
    else $error("bypass mode bits wrong");
  auto_loop_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ15
    (wr_dll && dev_wdata[`DL_LOOP_ON_BIT]) |-> dll_auto && !dev_wdata[`DL_LOAD_BIT]
    && !dev_wdata[`DL_BYPASS_BIT]) else $error("loop on with load or bypass");
  sdr_timing_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ16
    (wr_tim && !ddr_mode) |-> dev_wdata[19:0] == 20'h00303)
    else $error("sdr timing wrong");
  ddr_timing_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ17
    (wr_tim && ddr_mode) |-> dev_wdata[19:0] == 20'h10303)
    else $error("ddr timing wrong");
  ratio_reject_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ20
    (clk_en && state_q == flash_setup_pkg::ST_CHECK && 16'h0005 * flash_mhz <= bus_mhz)
    |=> error && error_code == 3'h4 && !busy) else $error("bad clock ratio accepted");
  lock_before_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ12
    (wr_dll && !dll_auto && step_q == 4'hb) |-> $past(lock_seen, 2))
    else $error("load cleared before lock");
endmodule
`default_nettype wire

/* src/flash_setup_cfg.svh */
// Summary of operation
// RQ1 - Flash address must fall inside mapped window
// RQ2 - Addressless commands load window base address
// RQ3 - Column width zero when flash lacks columns
// RQ4 - Device splits 24-bit address into page, column
// RQ5 - Page plus column width at most 32
// RQ6 - Device halves byte address when word addressable
// RQ7 - Four top-address registers map each flash
// RQ8 - Module control field picks read strobe source
// RQ9 - Pad loopback returns internal clock as strobe
// RQ10 - Loopback up to 133/66 MHz, else external
// RQ11 - External strobe samples read data
// RQ12 - Bypass: enable, delays, load, poll, clear load
// RQ13 - Auto mode searches T/16 delay steps
// RQ14 - Auto mode reloads slave chain on relock
// RQ15 - Auto: enable, setup, load, loop on, poll
// RQ16 - SDR: no DDR, hold 0, select 3/3
// RQ17 - DDR: DDR on, hold 1, select 3/3
// RQ18 - Lookup table holds 16 sequences of 10
// RQ19 - Writing sequence index starts that sequence
// RQ20 - Flash clock above one fifth bus clock
// RQ21 - DDR writes: 3F plus 3B below 8F
// RQ22 - Host domain clocks share one 133 MHz source
// RQ23 - Device runs stored pairs until stop or last
`ifndef FLASH_SETUP_CFG_SVH
`define FLASH_SETUP_CFG_SVH

`define OFS_MODULE_CTRL   16'h0000
`define OFS_IP_COMMAND    16'h0008
`define OFS_TIMING        16'h000c
`define OFS_DLL_CTRL_A    16'h0060
`define OFS_FLASH_ADDR    16'h0100
`define OFS_ADDR_CFG      16'h0104
`define OFS_TOP_A1        16'h0180
`define OFS_TOP_A2        16'h0184
`define OFS_TOP_B1        16'h0188
`define OFS_TOP_B2        16'h018c
`define OFS_LOCK_STATUS   16'h012c

`define MC_DDR_EN_BIT     7
`define MC_STROBE_A_BIT   24
`define TM_SETUP_LSB      0
`define TM_HOLD_LSB       8
`define TM_DHOLD_LSB      16
`define TM_CS_CYCLES      4'h3
`define TM_DHOLD_SDR      2'h0
`define TM_DHOLD_DDR      2'h1
`define AC_COL_LSB        0
`define AC_WORD_BIT       16
`define DL_LOOP_ON_BIT    0
`define DL_LOAD_BIT       1
`define DL_CHAIN_EN_BIT   2
`define DL_AUTO_BIT       3
`define DL_FREQ_BIT       4
`define DL_BYPASS_BIT     8
`define DL_COARSE_LSB     9
`define DL_FINE_LSB       13
`define DL_OFFSET_LSB     16
`define DL_RES_LSB        20
`define DL_REF_LSB        28
`define LS_LOCK_BIT       0
`define IPC_SEQ_LSB       24

`define WINDOW_BASE       32'h0000_0000
`define WINDOW_TOP        32'h1fff_ffff
`define MAX_ADDR_BITS     7'h20
`define SEQ_COUNT         5'h10
`define SDR_LOOP_MHZ      9'h085
`define DDR_LOOP_MHZ      9'h042
`define RATIO_MIN         16'h0005
`define WR_FLASH_PERIODS  16'h0003
`define WR_BUS_PERIODS    16'h0003
`define WR_LIMIT_PERIODS  16'h0008
`define POLL_LIMIT_DEF    1000
`define LAST_STEP         4'hd

`endif

/* src/flash_setup_pkg.sv */
package flash_setup_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_ISSUE = 2'b11,
    ST_WAIT  = 2'b10
  } host_state_e;

  typedef enum logic [2:0] {
    ERR_NONE   = 3'h0,
    ERR_WINDOW = 3'h1,
    ERR_WIDTH  = 3'h2,
    ERR_INDEX  = 3'h3,
    ERR_CLOCK  = 3'h4,
    ERR_LOCK   = 3'h5
  } host_error_e;
endpackage

/* src/reg_port_engine.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries one register read or write to the device and waits for its ack
module reg_port_engine (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        op_valid,
  input  wire logic        op_write,
  input  wire logic [15:0] op_addr,
  input  wire logic [31:0] op_wdata,
  output logic             op_done,
  output logic [31:0]      op_rdata,
  output logic [15:0]      dev_addr,
  output logic [31:0]      dev_wdata,
  output logic             dev_wr_en,
  output logic             dev_rd_en,
  input  wire logic [31:0] dev_rdata,
  input  wire logic        dev_ack
);
  logic [15:0] addr_q, addr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic        wr_q, wr_d, rd_q, rd_d, done_q, done_d;

  always_comb begin
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    wr_d    = wr_q;
    rd_d    = rd_q;
    done_d  = 1'b0;
    if (!(wr_q || rd_q)) begin
      if (op_valid) begin
        addr_d  = op_addr;
        wdata_d = op_write ? op_wdata : 32'h0000_0000;
        wr_d    = op_write;
        rd_d    = !op_write;
      end
    end else if (dev_ack) begin
      wr_d    = 1'b0;
      rd_d    = 1'b0;
      done_d  = 1'b1;
      rdata_d = rd_q ? dev_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      addr_q  <= 16'h0000;
      wdata_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      done_q  <= 1'b0;
    end else if (clk_en) begin
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      done_q  <= done_d;
    end
  end

  assign op_done   = done_q;
  assign op_rdata  = rdata_q;
  assign dev_addr  = addr_q;
  assign dev_wdata = wdata_q;
  assign dev_wr_en = wr_q;
  assign dev_rd_en = rd_q;

  strobe_held_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && (wr_q || rd_q) && !dev_ack) |=> (wr_q || rd_q) && $stable(addr_q))
    else $error("strobe dropped before ack");
endmodule
`default_nettype wire

/* verification/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_setup_cfg.svh"
// Behavioural device: register file, stalling ack, lock flag
module flash_dev_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] dev_addr,
  input  wire logic [31:0] dev_wdata,
  input  wire logic        dev_wr_en,
  input  wire logic        dev_rd_en,
  output logic [31:0]      dev_rdata,
  output logic             dev_ack,
  input  wire logic [2:0]  ack_delay,
  input  wire logic        never_lock
);
  logic [31:0] regs_q [0:15];
  logic [31:0] flash_loc_q;
  logic [2:0]  wait_q;
  logic [1:0]  polls_q;
  logic        locked_q;
  logic        word_mode_q;
  logic [3:0]  seq_run_q;
  logic [31:0] val;
  always_comb begin
    case (dev_addr)
      `OFS_LOCK_STATUS: val = {31'h0, locked_q};
      `OFS_DLL_CTRL_A:  val = regs_q[1];
      default:          val = regs_q[dev_addr[5:2]];
    endcase
    // Released bus shows the inverse rather than stale data
    dev_rdata = dev_rd_en ? val : ~val;
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dev_ack <= 1'b0;
      wait_q <= 3'h0;
      polls_q <= 2'h0;
      locked_q <= 1'b0;
      seq_run_q <= 4'h0;
      flash_loc_q <= 32'h0;
      word_mode_q <= 1'b0;
      for (int i = 0; i < 16; i++) regs_q[i] <= 32'h0;
    end else if (dev_ack) begin
      dev_ack <= 1'b0;
      wait_q <= 3'h0;
    end else if (dev_wr_en || dev_rd_en) begin
      wait_q <= wait_q + 3'h1;
      dev_ack <= (wait_q >= ack_delay);
      if (wait_q >= ack_delay && dev_wr_en) begin
        // top addresses and strobe select kept, clear means pad loopback
        regs_q[dev_addr[5:2]] <= dev_wdata;
        if (dev_addr == `OFS_DLL_CTRL_A) regs_q[1] <= dev_wdata;
        // Writing the chain mode without load or loop drops the lock
        if (dev_addr == `OFS_DLL_CTRL_A && !dev_wdata[`DL_LOAD_BIT]
            && !dev_wdata[`DL_LOOP_ON_BIT]) begin
          locked_q <= 1'b0;
          polls_q <= 2'h0;
        end
        if (dev_addr == `OFS_ADDR_CFG) word_mode_q <= dev_wdata[`AC_WORD_BIT];
        // word mode halves the mapped address
        if (dev_addr == `OFS_FLASH_ADDR)
          flash_loc_q <= word_mode_q ? dev_wdata >> 1 : dev_wdata;
        // index write starts a stored sequence
        if (dev_addr == `OFS_IP_COMMAND) seq_run_q <= dev_wdata[27:24];
      end
      // lock after a few polls once loaded or looping
      if (wait_q >= ack_delay && dev_rd_en && !never_lock
          && (regs_q[1][`DL_LOAD_BIT] || regs_q[1][`DL_LOOP_ON_BIT])) begin
        polls_q <= polls_q + 2'h1;
        locked_q <= locked_q | (polls_q == 2'h1);
      end
    end
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_setup_cfg.svh"
module tb;
  logic        clk_sys = 0, reset_n = 0, clk_en = 1, start = 0;
  logic        ddr_mode = 0, dll_auto = 0, has_address = 1, word_addressable = 0;
  logic [3:0]  column_width = 0, coarse_delay = 0, delay_offset = 0;
  logic [3:0]  ref_count = 0, delay_resolution = 0;
  logic [5:0]  page_width = 0;
  logic [8:0]  flash_mhz = 9'h064, bus_mhz = 9'h085;
  logic [31:0] top_addr = 0, flash_addr = 0, dev_wdata, dev_rdata;
  logic [4:0]  sequence_index = 0;
  logic [2:0]  fine_delay = 0, error_code, ack_delay = 0;
  logic        freq_range_sel = 0, never_lock = 0, busy, done, error;
  logic [15:0] dev_addr;
  logic        dev_wr_en, dev_rd_en, dev_ack, pend, last_err;
  int          failures = 0, compares = 0, seed = 91280;
  logic [47:0] wr_q [$];
  logic [3:0]  res_q [$];
  initial forever #50 clk_sys = ~clk_sys;
  flash_setup_host #(.POLL_LIMIT(4)) flash_setup_host_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .clk_en(clk_en), .start(start), .ddr_mode(ddr_mode),
    .dll_auto(dll_auto), .has_address(has_address), .word_addressable(word_addressable),
    .column_width(column_width), .page_width(page_width), .flash_mhz(flash_mhz),
    .bus_mhz(bus_mhz), .top_addr(top_addr), .flash_addr(flash_addr),
    .sequence_index(sequence_index), .coarse_delay(coarse_delay), .fine_delay(fine_delay),
    .delay_offset(delay_offset), .freq_range_sel(freq_range_sel), .ref_count(ref_count),
    .delay_resolution(delay_resolution), .busy(busy), .done(done), .error(error),
    .error_code(error_code), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr_en(dev_wr_en), .dev_rd_en(dev_rd_en), .dev_rdata(dev_rdata), .dev_ack(dev_ack));
  flash_dev_model flash_dev_model_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr_en(dev_wr_en),
    .dev_rd_en(dev_rd_en), .dev_rdata(dev_rdata), .dev_ack(dev_ack),
    .ack_delay(ack_delay), .never_lock(never_lock));
  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Monitor: register writes and the result of each run
  always @(posedge clk_sys) begin
    if (pend === 1'b1)
      check("result", {44'h0, last_err, error_code}, {44'h0, res_q.pop_front()});
    pend = (done === 1'b1) || (error === 1'b1);
    last_err = error;
    if (dev_wr_en === 1'b1 && dev_ack === 1'b1) begin
      if (wr_q.size() == 0) check("extra write", {dev_addr, dev_wdata}, 48'h0);
      else check("register write", {dev_addr, dev_wdata}, wr_q.pop_front());
    end
  end
  task automatic push(input logic [15:0] a, input logic [31:0] d);
    wr_q.push_back({a, d});
  endtask
  task automatic plan(input bit full);
    logic [31:0] mode;
    logic [31:0] flds;
    logic        ext;
    // same top address in all four map registers
    for (int i = 0; i < 4; i++) push(`OFS_TOP_A1 + 16'(4 * i), top_addr);
    push(`OFS_ADDR_CFG, {15'h0, word_addressable, 12'h0, column_width});
    ext = ddr_mode ? (flash_mhz > 9'h042) : (flash_mhz > 9'h085);
    push(`OFS_MODULE_CTRL, {7'h0, ext, 16'h0, ddr_mode, 7'h0});
    push(`OFS_TIMING, {14'h0, 1'b0, ddr_mode, 4'h0, 4'h3, 4'h0, 4'h3});
    // delay chain mode, fields and load
    mode = dll_auto ? 32'h0000_000c : 32'h0000_0104;
    flds = mode | (32'(fine_delay) << 13) | (32'(freq_range_sel) << 4);
    if (dll_auto) flds = flds | (32'(delay_offset) << 16) | (32'(delay_resolution) << 20)
                              | (32'(ref_count) << 28);
    else flds = flds | (32'(coarse_delay) << 9);
    push(`OFS_DLL_CTRL_A, mode);
    push(`OFS_DLL_CTRL_A, flds);
    push(`OFS_DLL_CTRL_A, flds | 32'h2);
    if (!full) return;
    push(`OFS_DLL_CTRL_A, dll_auto ? (flds | 32'h1) : flds);
    push(`OFS_FLASH_ADDR, has_address ? flash_addr : `WINDOW_BASE);
    // index written to start the sequence
    push(`OFS_IP_COMMAND, {4'h0, sequence_index[3:0], 24'h0});
  endtask
  task automatic go(input logic [2:0] code);
    int n;
    logic [31:0] loc;
    coarse_delay = 4'($random(seed));
    fine_delay = 3'($random(seed));
    freq_range_sel = 1'($random(seed));
    if (code == 3'h0) plan(1'b1);
    else if (code == 3'h5) plan(1'b0);
    res_q.push_back({code != 3'h0, code});
    @(negedge clk_sys) start = 1;
    @(negedge clk_sys) start = 0;
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk_sys);
    if (n == 3000) begin
      failures++;
      give_verdict();
    end
    repeat (2) @(negedge clk_sys);
    check("writes left", 48'(wr_q.size()), 48'h0);
    loc = has_address ? flash_addr : `WINDOW_BASE;
    if (word_addressable) loc = loc >> 1;
    if (code == 3'h0) begin
      check("flash location", 48'(flash_dev_model_inst.flash_loc_q), 48'(loc));
      check("sequence", 48'(flash_dev_model_inst.seq_run_q), 48'(sequence_index[3:0]));
    end
  endtask
  initial begin
    delay_offset = 4'($random(seed));
    ref_count = 4'($random(seed));
    delay_resolution = 4'($random(seed));
    top_addr = 32'h0400_0000;
    repeat (8) @(negedge clk_sys);
    reset_n = 1;
    // SDR bypass, window top, last index
    {word_addressable, column_width, page_width} = {1'b1, 4'h3, 6'h18};
    {flash_addr, sequence_index} = {`WINDOW_TOP, 5'h0f};
    go(3'h0);
    {ddr_mode, dll_auto, flash_mhz, has_address} = {1'b1, 1'b1, 9'h0c8, 1'b0};
    {flash_addr, page_width, column_width, ack_delay} = {32'h2000_0000, 6'h20, 4'h0, 3'h3};
    sequence_index = 5'h00;
    go(3'h0);
    // loopback at the DDR limit, external strobe just above the SDR limit
    {flash_mhz, has_address, flash_addr, top_addr} = {9'h042, 1'b1, 32'h0000_2004, 32'h0};
    go(3'h0);
    {ddr_mode, dll_auto, flash_mhz, ack_delay} = {1'b0, 1'b0, 9'h086, 3'h0};
    go(3'h0);
    for (int i = 0; i < 5; i++) begin
      {flash_addr, column_width, sequence_index} = {32'h1000_0000, 4'h3, 5'h07};
      {ddr_mode, flash_mhz} = {1'b0, 9'h064};
      case (i)
        0: flash_addr = 32'h2000_0000;
        1: page_width = 6'h1e;
        2: sequence_index = 5'h10;
        3: flash_mhz = 9'h01a;
        default: {ddr_mode, flash_mhz} = {1'b1, 9'h0de};
      endcase
      go(i == 0 ? 3'h1 : i == 1 ? 3'h2 : i == 2 ? 3'h3 : 3'h4);
      page_width = 6'h18;
    end
    {ddr_mode, flash_mhz} = {1'b0, 9'h064};
    never_lock = 1;
    go(3'h5);
    never_lock = 0;
    go(3'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
